// file: hw/portb_pkg.sv
package portb_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 20;
    localparam logic [19:0] PIN_DIRECTION_ADDR = 20'hee00a;
    localparam logic [19:0] PIN_OUTPUT_DATA_ADDR = 20'hfffda;
    localparam logic [7:0] PIN_DIRECTION_RST = 8'h00;
    localparam logic [7:0] PIN_OUTPUT_DATA_RST = 8'h00;
    localparam logic [7:0] WO_READBACK = 8'hff;
    localparam int BIT_B3 = 3;
    localparam int BIT_B4 = 4;
    localparam int BIT_B5 = 5;
    localparam int BIT_B6 = 6;
    localparam int BIT_B7 = 7;
    localparam int SYNC_STAGES = 2;
    // One-hot pin function codes
    typedef enum logic [5:0] {
        FN_INPUT = 6'b000001,
        FN_GPO = 6'b000010,
        FN_PATTERN = 6'b000100,
        FN_PERIPH_OUT = 6'b001000,
        FN_PERIPH_IN = 6'b010000,
        FN_PERIPH_OD = 6'b100000
    } pin_fn_t;
endpackage

// file: hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync width must be positive");
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// file: hw/pin_func_sel.sv
`timescale 1ns/1ns
module pin_func_sel (
    input wire logic [7:0] dir,
    input wire logic [7:0] dout,
    input wire logic [7:0] pattern_enable_reg_high,
    input wire logic [7:0] pattern_data,
    input wire logic smart_card_select,
    input wire logic serial_receive_enable,
    input wire logic serial_transmit_enable,
    input wire logic serial_transmit_output,
    input wire logic serial_transmit_drive,
    input wire logic sync_mode,
    input wire logic internal_clock_enable,
    input wire logic external_clock_enable,
    input wire logic serial_clock_out,
    input wire logic lower_cas_sel,
    input wire logic lower_column_strobe,
    input wire logic upper_cas_sel,
    input wire logic upper_column_strobe,
    input wire logic bit3_periph_sel,
    input wire logic bit3_periph_val,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe
);
    import portb_pkg::*;
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pin_oe[i] = dir[i];
            pin_o[i] = pattern_enable_reg_high[i] ? pattern_data[i] : dout[i];
        end
        if (smart_card_select || serial_receive_enable) begin
            pin_oe[BIT_B7] = 1'b0;
            pin_o[BIT_B7] = 1'b0;
        end
        if (smart_card_select || serial_transmit_enable) begin
            pin_o[BIT_B6] = serial_transmit_output;
            pin_oe[BIT_B6] = smart_card_select ? serial_transmit_drive : 1'b1;
        end
        if (external_clock_enable) begin
            pin_oe[BIT_B5] = 1'b0;
            pin_o[BIT_B5] = 1'b0;
        end else if (sync_mode || internal_clock_enable) begin
            pin_oe[BIT_B5] = 1'b1;
            pin_o[BIT_B5] = serial_clock_out;
        end
        if (lower_cas_sel) begin
            pin_oe[BIT_B5] = 1'b1;
            pin_o[BIT_B5] = lower_column_strobe;
        end
        if (upper_cas_sel) begin
            pin_oe[BIT_B4] = 1'b1;
            pin_o[BIT_B4] = upper_column_strobe;
        end
        if (bit3_periph_sel) begin
            pin_oe[BIT_B3] = 1'b1;
            pin_o[BIT_B3] = bit3_periph_val;
        end
    end
endmodule

// file: hw/port_b_gpio_pin_select.sv
`timescale 1ns/1ns
module port_b_gpio_pin_select #(
    parameter int PORT_WIDTH = portb_pkg::PORT_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hw_standby,
    input wire logic [portb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    input wire logic [7:0] pattern_enable_reg_high,
    input wire logic [7:0] pattern_data,
    input wire logic smart_card_select,
    input wire logic serial_receive_enable,
    input wire logic serial_transmit_enable,
    input wire logic serial_transmit_output,
    input wire logic serial_transmit_drive,
    input wire logic sync_mode,
    input wire logic internal_clock_enable,
    input wire logic external_clock_enable,
    input wire logic serial_clock_out,
    input wire logic [2:0] dram_area_sel,
    input wire logic strobe_select,
    input wire logic lower_column_strobe,
    input wire logic upper_column_strobe,
    input wire logic [3:0] timer_output_select,
    input wire logic [1:0] counter_clear_sel,
    input wire logic timer3_io,
    input wire logic chip_select4_enable,
    input wire logic chip_select4_n,
    input wire logic dma_ext_request_sel,
    output logic dma_request_one,
    output logic serial_receive_input,
    output logic serial_clock_in,
    output logic timer3_in
);
    import portb_pkg::*;

    logic [7:0] pin_direction_ff;
    logic [7:0] pin_output_data_ff;
    logic [7:0] pin_sync;
    logic [7:0] sel_o;
    logic [7:0] sel_oe;
    logic [7:0] nxt_rdata;
    logic dram_cas_area;
    logic lower_cas_sel;
    logic upper_cas_sel;
    logic bit3_periph_sel;
    logic bit3_periph_val;
    logic timer3_out_sel;
    logic cs4_sel;

    initial begin
        if (PORT_WIDTH != PORT_W) begin
            $error("port width must be eight");
        end
    end

    pin_sync #(.WIDTH(PORT_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in(pin_i),
        .sync_out(pin_sync)
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_direction_ff <= PIN_DIRECTION_RST;
        end else if (hw_standby) begin
            pin_direction_ff <= PIN_DIRECTION_RST;
        end else if (reg_wr && reg_addr == PIN_DIRECTION_ADDR) begin
            pin_direction_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_output_data_ff <= PIN_OUTPUT_DATA_RST;
        end else if (hw_standby) begin
            pin_output_data_ff <= PIN_OUTPUT_DATA_RST;
        end else if (reg_wr && reg_addr == PIN_OUTPUT_DATA_ADDR) begin
            pin_output_data_ff <= reg_wdata;
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_addr == PIN_DIRECTION_ADDR) begin
            nxt_rdata = WO_READBACK;
        end else if (reg_addr == PIN_OUTPUT_DATA_ADDR) begin
            nxt_rdata = (pin_direction_ff & pin_output_data_ff)
                | (~pin_direction_ff & pin_sync);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Every nonzero DRAM area select encoding (1..7) gives the upper column strobe, and the lower one with strobe_select
    assign dram_cas_area = (dram_area_sel != 3'h0);
    assign lower_cas_sel = dram_cas_area && strobe_select;
    assign upper_cas_sel = dram_cas_area;

    assign timer3_out_sel = (timer_output_select != 4'h0);
    assign cs4_sel = chip_select4_enable || (dram_area_sel == 3'h5);
    assign bit3_periph_sel = cs4_sel || timer3_out_sel;
    assign bit3_periph_val = cs4_sel ? chip_select4_n : timer3_io;

    pin_func_sel u_sel (
        .dir(pin_direction_ff),
        .dout(pin_output_data_ff),
        .pattern_enable_reg_high(pattern_enable_reg_high),
        .pattern_data(pattern_data),
        .smart_card_select(smart_card_select),
        .serial_receive_enable(serial_receive_enable),
        .serial_transmit_enable(serial_transmit_enable),
        .serial_transmit_output(serial_transmit_output),
        .serial_transmit_drive(serial_transmit_drive),
        .sync_mode(sync_mode),
        .internal_clock_enable(internal_clock_enable),
        .external_clock_enable(external_clock_enable),
        .serial_clock_out(serial_clock_out),
        .lower_cas_sel(lower_cas_sel),
        .lower_column_strobe(lower_column_strobe),
        .upper_cas_sel(upper_cas_sel),
        .upper_column_strobe(upper_column_strobe),
        .bit3_periph_sel(bit3_periph_sel),
        .bit3_periph_val(bit3_periph_val),
        .pin_o(sel_o),
        .pin_oe(sel_oe)
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_o <= 8'h00;
            pin_oe <= 8'h00;
        end else if (hw_standby) begin
            pin_o <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_o <= sel_o;
            pin_oe <= sel_oe;
        end
    end

    // DMA request from bit 3 pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dma_request_one <= 1'b1;
        end else begin
            dma_request_one <= dma_ext_request_sel ? pin_sync[BIT_B3] : 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serial_receive_input <= 1'b1;
            serial_clock_in <= 1'b0;
            timer3_in <= 1'b0;
        end else begin
            serial_receive_input <= pin_sync[BIT_B7];
            serial_clock_in <= pin_sync[BIT_B5];
            timer3_in <= (counter_clear_sel == 2'h3) ? pin_sync[BIT_B3] : 1'b0;
        end
    end

    chk_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == PIN_DIRECTION_ADDR && !hw_standby
        |=> pin_direction_ff == $past(reg_wdata))
        else $error("direction write lost");
    chk_dir_readback: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && reg_addr == PIN_DIRECTION_ADDR |=> reg_rdata == 8'hff)
        else $error("direction read not all ones");
    chk_hwstby_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hw_standby |=> pin_direction_ff == 8'h00 && pin_output_data_ff == 8'h00)
        else $error("standby did not clear");
    chk_data_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && reg_addr == PIN_OUTPUT_DATA_ADDR
        |=> reg_rdata == (($past(pin_direction_ff) & $past(pin_output_data_ff))
            | (~$past(pin_direction_ff) & $past(pin_sync))))
        else $error("data readback wrong");
    chk_data_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && !(reg_wr && reg_addr == PIN_OUTPUT_DATA_ADDR)
        |=> $stable(pin_output_data_ff))
        else $error("data changed without write");
    chk_gpo_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && pin_direction_ff[0] && !pattern_enable_reg_high[0]
        |=> pin_oe[0] && pin_o[0] == $past(pin_output_data_ff[0]))
        else $error("general output not driven");
    chk_upper_column_strobe_take: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && upper_cas_sel |=> pin_oe[BIT_B4])
        else $error("upper strobe not driven");
    chk_rx_input: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && serial_receive_enable |=> !pin_oe[BIT_B7])
        else $error("receive pin driven");
    chk_dma_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dma_ext_request_sel |=> dma_request_one == $past(pin_sync[BIT_B3]))
        else $error("dma request wrong");
    chk_dir_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && !(reg_wr && reg_addr == PIN_DIRECTION_ADDR)
        |=> $stable(pin_direction_ff))
        else $error("direction changed without write");
    chk_data_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == PIN_OUTPUT_DATA_ADDR && !hw_standby
        |=> pin_output_data_ff == $past(reg_wdata))
        else $error("data write lost");
    chk_tx_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && serial_transmit_enable && !smart_card_select
        |=> pin_oe[BIT_B6] && pin_o[BIT_B6] == $past(serial_transmit_output))
        else $error("transmit pin not driven");
    chk_smart_hiz: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && smart_card_select
        |=> pin_oe[BIT_B6] == $past(serial_transmit_drive) && !pin_oe[BIT_B7])
        else $error("smart-card pin state wrong");
    chk_sck_input: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && external_clock_enable && !lower_cas_sel
        |=> !pin_oe[BIT_B5])
        else $error("clock input pin driven");
    chk_sck_output: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && !external_clock_enable && !lower_cas_sel
        && (sync_mode || internal_clock_enable)
        |=> pin_oe[BIT_B5] && pin_o[BIT_B5] == $past(serial_clock_out))
        else $error("clock output pin wrong");
    chk_lower_column_strobe_take: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && lower_cas_sel
        |=> pin_oe[BIT_B5] && pin_o[BIT_B5] == $past(lower_column_strobe))
        else $error("lower strobe not driven");
    chk_pattern_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && !upper_cas_sel && pin_direction_ff[BIT_B4]
        && pattern_enable_reg_high[BIT_B4]
        |=> pin_oe[BIT_B4] && pin_o[BIT_B4] == $past(pattern_data[BIT_B4]))
        else $error("pattern output wrong");
    chk_input_pin: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && !upper_cas_sel && !pin_direction_ff[BIT_B4]
        |=> !pin_oe[BIT_B4])
        else $error("input pin driven");
    chk_standby_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hw_standby |=> pin_oe == 8'h00)
        else $error("pins driven in standby");
    chk_bit3_periph: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !hw_standby && bit3_periph_sel
        |=> pin_oe[BIT_B3] && pin_o[BIT_B3] == $past(bit3_periph_val))
        else $error("bit 3 peripheral output wrong");
    chk_t3_input: assert property (@(posedge clk_sys) disable iff (!rst_b)
        counter_clear_sel == 2'h3 |=> timer3_in == $past(pin_sync[BIT_B3]))
        else $error("timer input wrong");
    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

    cov_dir_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == PIN_DIRECTION_ADDR);
    cov_data_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && reg_addr == PIN_OUTPUT_DATA_ADDR && pin_direction_ff != 8'h00);
    cov_lower_column_strobe: cover property (@(posedge clk_sys) disable iff (!rst_b) lower_cas_sel);
    cov_smart_drive: cover property (@(posedge clk_sys) disable iff (!rst_b)
        smart_card_select && serial_transmit_drive);
    cov_dma_sel: cover property (@(posedge clk_sys) disable iff (!rst_b)
        dma_ext_request_sel && pin_sync[BIT_B3]);
endmodule

// file: testbench/board_model.sv
`timescale 1ns/1ns
module board_model (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_i
);
    // resolved pin level
    // Board drives only the pins that the port has released
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
    import portb_pkg::*;
    logic clk_sys = 1'h0, rst_b = 1'h0, hw_standby = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [ADDR_W-1:0] reg_addr = 20'h00000;
    logic [7:0] reg_wdata = 8'h00, ext_val = 8'h96, pattern_enable_reg_high = 8'h00;
    logic [7:0] pattern_data = 8'h00, reg_rdata, pin_i, pin_o, pin_oe, rv;
    logic smart_card_select = 1'h0, serial_receive_enable = 1'h0, sync_mode = 1'h0;
    logic serial_transmit_enable = 1'h0, serial_transmit_output = 1'h0;
    logic serial_transmit_drive = 1'h0, serial_clock_out = 1'h0;
    logic internal_clock_enable = 1'h0, external_clock_enable = 1'h0;
    logic [2:0] dram_area_sel = 3'h0;
    logic strobe_select = 1'h0, lower_column_strobe = 1'h0, upper_column_strobe = 1'h0;
    logic [3:0] timer_output_select = 4'h0;
    logic [1:0] counter_clear_sel = 2'h0;
    logic timer3_io = 1'h0, chip_select4_enable = 1'h0, chip_select4_n = 1'h1;
    logic dma_ext_request_sel = 1'h0;
    logic dma_request_one, serial_receive_input, serial_clock_in, timer3_in;
    int n_errors = 0, n_compared = 0, cycles = 0;

    port_b_gpio_pin_select DUT (.clk_sys, .rst_b, .hw_standby, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .pin_i, .pin_o, .pin_oe, .pattern_enable_reg_high,
        .pattern_data, .smart_card_select, .serial_receive_enable, .serial_transmit_enable,
        .serial_transmit_output, .serial_transmit_drive, .sync_mode, .internal_clock_enable,
        .external_clock_enable, .serial_clock_out, .dram_area_sel, .strobe_select,
        .lower_column_strobe, .upper_column_strobe, .timer_output_select,
        .counter_clear_sel, .timer3_io, .chip_select4_enable, .chip_select4_n,
        .dma_ext_request_sel, .dma_request_one, .serial_receive_input, .serial_clock_in,
        .timer3_in);
    board_model board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val), .pin_i(pin_i));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    // Read strobe for one cycle, data sampled in the cycle after it
    task automatic rchk(input string nm, input logic [19:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    // Covers the two-flop pin synchroniser plus the registered outputs
    task automatic settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic complete_run;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        settle();
        chk("pin_oe", 8'h00, pin_oe);
        chk("pin_o", 8'h00, pin_o);
        rchk("dir", PIN_DIRECTION_ADDR, WO_READBACK);
        rchk("data", PIN_OUTPUT_DATA_ADDR, 8'h96);
        wr(PIN_DIRECTION_ADDR, 8'hff);
        wr(PIN_OUTPUT_DATA_ADDR, 8'ha5);
        settle();
        chk("pin_oe", 8'hff, pin_oe);
        chk("pin_o", 8'ha5, pin_o);
        rchk("data", PIN_OUTPUT_DATA_ADDR, 8'ha5);
        rchk("dir", PIN_DIRECTION_ADDR, WO_READBACK);
        wr(PIN_DIRECTION_ADDR, 8'h0f);
        wr(PIN_OUTPUT_DATA_ADDR, 8'h3c);
        ext_val <= 8'h69;
        settle();
        chk("pin_oe", 8'h0f, pin_oe);
        chk("pin_o", 8'h0c, pin_o & 8'h0f);
        rchk("data", PIN_OUTPUT_DATA_ADDR, 8'h6c);
        wr(20'h00001, 8'hff);
        rchk("unmapped", 20'h00001, 8'h00);
        rchk("data", PIN_OUTPUT_DATA_ADDR, 8'h6c);
        pattern_enable_reg_high <= 8'hf0;
        pattern_data <= 8'haa;
        settle();
        chk("pin_oe", 8'h0f, pin_oe);
        wr(PIN_DIRECTION_ADDR, 8'hff);
        settle();
        chk("pin_o", 8'hac, pin_o);
        pattern_enable_reg_high <= 8'h00;
        wr(PIN_OUTPUT_DATA_ADDR, 8'hff);
        serial_receive_enable <= 1'h1;
        serial_transmit_enable <= 1'h1;
        ext_val <= 8'h00;
        settle();
        chk("pin_oe", 8'h7f, pin_oe);
        chk("pin_o b6", 8'h00, pin_o & 8'h40);
        chk("rx", 8'h00, {7'h00, serial_receive_input});
        serial_receive_enable <= 1'h0;
        serial_transmit_enable <= 1'h0;
        smart_card_select <= 1'h1;
        settle();
        chk("pin_oe", 8'h3f, pin_oe);
        serial_transmit_drive <= 1'h1;
        serial_transmit_output <= 1'h1;
        settle();
        chk("pin_oe", 8'h7f, pin_oe);
        chk("pin_o b6", 8'h40, pin_o & 8'h40);
        smart_card_select <= 1'h0;
        external_clock_enable <= 1'h1;
        ext_val <= 8'h20;
        settle();
        chk("pin_oe", 8'hdf, pin_oe);
        chk("sck in", 8'h01, {7'h00, serial_clock_in});
        external_clock_enable <= 1'h0;
        sync_mode <= 1'h1;
        settle();
        chk("pin_oe", 8'hff, pin_oe);
        chk("pin_o b5", 8'h00, pin_o & 8'h20);
        sync_mode <= 1'h0;
        internal_clock_enable <= 1'h1;
        serial_clock_out <= 1'h1;
        settle();
        chk("pin_o b5", 8'h20, pin_o & 8'h20);
        serial_clock_out <= 1'h0;
        dram_area_sel <= 3'h1;
        strobe_select <= 1'h1;
        lower_column_strobe <= 1'h1;
        settle();
        chk("pin_o b54", 8'h20, pin_o & 8'h30);
        chk("pin_oe b54", 8'h30, pin_oe & 8'h30);
        strobe_select <= 1'h0;
        upper_column_strobe <= 1'h1;
        settle();
        chk("pin_o b54", 8'h10, pin_o & 8'h30);
        dram_area_sel <= 3'h0;
        sync_mode <= 1'h0;
        internal_clock_enable <= 1'h0;
        timer_output_select <= 4'h1;
        settle();
        chk("pin_o b3", 8'h00, pin_o & 8'h08);
        timer_output_select <= 4'h0;
        chip_select4_enable <= 1'h1;
        chip_select4_n <= 1'h0;
        settle();
        chk("pin_o b3", 8'h00, pin_o & 8'h08);
        chip_select4_enable <= 1'h0;
        dram_area_sel <= 3'h5;
        settle();
        chk("pin_o b3", 8'h00, pin_o & 8'h08);
        dram_area_sel <= 3'h0;
        dma_ext_request_sel <= 1'h1;
        counter_clear_sel <= 2'h3;
        wr(PIN_DIRECTION_ADDR, 8'h00);
        ext_val <= 8'h00;
        settle();
        chk("dreq t3", 8'h00, {6'h00, dma_request_one, timer3_in});
        ext_val <= 8'h08;
        settle();
        chk("dreq t3", 8'h03, {6'h00, dma_request_one, timer3_in});
        wr(PIN_DIRECTION_ADDR, 8'hff);
        hw_standby <= 1'h1;
        settle();
        chk("pin_oe", 8'h00, pin_oe);
        wr(PIN_OUTPUT_DATA_ADDR, 8'hff);
        hw_standby <= 1'h0;
        settle();
        chk("pin_o", 8'h00, pin_o);
        rchk("data", PIN_OUTPUT_DATA_ADDR, 8'h08);
        wr(PIN_DIRECTION_ADDR, 8'hff);
        rst_b <= 1'h0;
        @(posedge clk_sys);
        rst_b <= 1'h1;
        settle();
        chk("pin_oe", 8'h00, pin_oe);
        complete_run();
    end
endmodule
